// [hdl/acc_pkg.sv]
// package: register map, field positions and codes of the comparator control block
package acc_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ACC_ADDR_W = 8;
	localparam int ACC_DATA_W = 32;
	localparam int ACC_IDX_W  = 6;
	localparam int ACC_REG_W  = 8;

	// ----------------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [5:0] ACC_IDX_DIS     = 6'h01;
	localparam logic [5:0] ACC_IDX_CTRL_B  = 6'h03;
	localparam logic [5:0] ACC_IDX_CSR     = 6'h08;
	localparam logic [5:0] ACC_IDX_IRQ_ST  = 6'h10;
	localparam logic [5:0] ACC_IDX_IRQ_MSK = 6'h11;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ACC_CSR_DISABLE = 7;
	localparam int ACC_CSR_REF     = 6;
	localparam int ACC_CSR_RESULT  = 5;
	localparam int ACC_CSR_FLAG    = 4;
	localparam int ACC_CSR_IE      = 3;
	localparam int ACC_CSR_CAPT    = 2;
	localparam int ACC_CSR_MODE_LO = 0;
	localparam int ACC_CTB_MUX_EN  = 6;
	localparam int ACC_IRQ_BIT     = 0;

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_CTB_RESET = 8'h00;
	localparam logic [7:0] ACC_CTB_WMASK = 8'hD7;
	localparam logic [7:0] ACC_CSR_RESET = 8'h00;
	localparam logic [7:0] ACC_CSR_STORE = 8'hCF;
	localparam logic [7:0] ACC_DIS_RESET = 8'h00;
	localparam logic [7:0] ACC_DIS_WMASK = 8'h03;

	// ----------------------------------------------------------------
	// event mode codes and negative input selection
	// ----------------------------------------------------------------
	localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
	localparam logic [1:0] ACC_MODE_RSVD   = 2'h1;
	localparam logic [1:0] ACC_MODE_FALL   = 2'h2;
	localparam logic [1:0] ACC_MODE_RISE   = 2'h3;
	localparam logic [4:0] ACC_CHAN_LAST   = 5'h07;
	localparam logic [3:0] ACC_NEG_PIN     = 4'h8;

	// bus slave states
	typedef enum logic {ACC_IDLE, ACC_ANSWER} acc_bus_state_type;

endpackage

// [hdl/acc_evt_if.sv]
// interface: synchronised result, event mode and event pulse between top and detector
`timescale 1ns/1ps
`default_nettype none
interface acc_evt_if;
	logic       result;
	logic [1:0] mode;
	logic       event_hit;
	modport ctrl (output result, output mode, input event_hit);
	modport det  (input result, input mode, output event_hit);
endinterface
`default_nettype wire

// [hdl/acc_sync.sv]
// module: multi-stage synchroniser for the raw comparator output
`timescale 1ns/1ps
`default_nettype none
module acc_sync
	import acc_pkg::*;
#(
	parameter int STAGES = 2
)(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic async_in,
	output var  logic sync_out
);
	typedef struct packed {
		logic [STAGES-1:0] chain;
	} acc_sync_state_type;

	acc_sync_state_type state_ff;
	acc_sync_state_type nxt_state;

	// shift chain; only the last stage is read outside
	always_comb begin
		nxt_state       = state_ff;
		nxt_state.chain = {state_ff.chain[STAGES-2:0], async_in};
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sync_out = state_ff.chain[STAGES-1];
endmodule
`default_nettype wire

// [hdl/acc_event.sv]
// module: edge and toggle detector on the synchronised comparator result
`timescale 1ns/1ps
`default_nettype none
module acc_event
	import acc_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	acc_evt_if.det    evt
);
	typedef struct packed {
		logic prev;
		logic primed;
	} acc_event_state_type;

	acc_event_state_type state_ff;
	acc_event_state_type nxt_state;
	logic                rise;
	logic                fall;

	// compare against the value one clock earlier; no event until primed,
	// so the first sample after reset never looks like an edge
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.prev   = evt.result;
		nxt_state.primed = 1'b1;
		rise = state_ff.primed & evt.result & ~state_ff.prev;
		fall = state_ff.primed & ~evt.result & state_ff.prev;
		case (evt.mode)
			ACC_MODE_TOGGLE: evt.event_hit = rise | fall;
			ACC_MODE_FALL:   evt.event_hit = fall;
			ACC_MODE_RISE:   evt.event_hit = rise;
			default:         evt.event_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule
`default_nettype wire

// [hdl/acc_top.sv]
// module: comparator control, event flag, input selection and register slave
//
// Contract
// - result bit is one while positive input exceeds negative input.
// - mux enabled and converter off: codes 0..7 pick channel pins 0..7.
// - mux disabled or converter on: dedicated negative pin is used.
// - reference select one picks bandgap, zero picks positive pin.
// - raw output is synchronised, one to two cycles latency.
// - event flag sets on the transition chosen by the mode field.
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - interrupt requested only with flag, enable and global enable all one.
// - taking the interrupt vector clears the event flag.
// - writing one to the flag position clears the flag.
// - writing one to the disable bit powers down the comparator, anytime.
// - capture route bit connects result to timer capture front end.
// - buffer disable bit turns buffer off and forces port read zero.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module acc_top
	import acc_pkg::*;
#(
	parameter int SYNC_STAGES = 2
)(
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// avalon-mm slave
	input  wire logic [ACC_ADDR_W-1:0] address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [ACC_DATA_W-1:0] writedata,
	output var  logic [ACC_DATA_W-1:0] readdata,
	output var  logic                  waitrequest,
	// surrounding processor and converter
	input  wire logic                  global_irq_enable,
	input  wire logic                  vector_taken,
	input  wire logic                  converter_enable,
	input  wire logic [4:0]            channel_select_code,
	// analog side
	input  wire logic                  comparator_raw,
	input  wire logic [1:0]            pin_digital_in,
	output var  logic                  comparator_power_down,
	output var  logic                  positive_bandgap_select,
	output var  logic [3:0]            negative_input_select,
	output var  logic [1:0]            pin_buffer_disable,
	output var  logic [1:0]            port_read_value,
	// timer capture front end and interrupt
	output var  logic                  capture_input,
	output var  logic                  comparator_irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		acc_bus_state_type     bus;
		logic                  wait_n;
		logic [ACC_DATA_W-1:0] rdata;
		logic [ACC_REG_W-1:0]  ctrl_b;
		logic [ACC_REG_W-1:0]  csr;
		logic [ACC_REG_W-1:0]  dis;
		logic                  irq;
		logic [3:0]            neg_sel;
		logic                  bandgap;
		logic                  pwr_dn;
		logic                  capture;
		logic [1:0]            port_rd;
	} acc_top_state_type;

	acc_top_state_type state_ff;
	acc_top_state_type nxt_state;

	// ----------------------------------------------------------------
	// synchroniser and event detector
	// ----------------------------------------------------------------
	logic      result_sync;
	acc_evt_if evt_bus ();

	// raw output crosses into the clock domain through the chain
	acc_sync #(
		.STAGES   (SYNC_STAGES)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (comparator_raw),
		.sync_out (result_sync)
	);

	assign evt_bus.result = result_sync;
	assign evt_bus.mode   = state_ff.csr[ACC_CSR_MODE_LO+1:ACC_CSR_MODE_LO];

	acc_event u_event (
		.clock (clock),
		.rst_n (rst_n),
		.evt   (evt_bus.det)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic [ACC_IDX_W-1:0] idx;
	logic                 req;
	logic                 commit_wr;
	logic [ACC_REG_W-1:0] wbyte;
	logic [ACC_REG_W-1:0] csr_view;
	logic                 flag_set;
	logic                 flag_clr;

	assign idx       = address[ACC_ADDR_W-1:2];
	assign req       = read | write;
	// a write lands at the edge where waitrequest is seen low
	assign commit_wr = write & (state_ff.bus == ACC_ANSWER);
	assign wbyte     = writedata[ACC_REG_W-1:0];

	// result bit is live, never stored, so writes cannot touch it
	always_comb begin
		csr_view                 = state_ff.csr;
		csr_view[ACC_CSR_RESULT] = result_sync;
	end

	// flag clear sources: vector fetch or a one written to the flag
	always_comb begin
		flag_set = evt_bus.event_hit;
		flag_clr = vector_taken;
		if (commit_wr && idx == ACC_IDX_CSR && wbyte[ACC_CSR_FLAG]) begin
			flag_clr = 1'b1;
		end
		if (commit_wr && idx == ACC_IDX_IRQ_ST && wbyte[ACC_IRQ_BIT]) begin
			flag_clr = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// one wait cycle, then answer; read data is loaded during the wait
		case (state_ff.bus)
			ACC_IDLE: begin
				if (req) begin
					nxt_state.bus    = ACC_ANSWER;
					nxt_state.wait_n = 1'b1;
				end
			end
			ACC_ANSWER: begin
				nxt_state.bus    = ACC_IDLE;
				nxt_state.wait_n = 1'b0;
			end
			default: begin
				nxt_state.bus    = ACC_IDLE;
				nxt_state.wait_n = 1'b0;
			end
		endcase

		// read mux; unmapped indices read zero
		if (state_ff.bus == ACC_IDLE && read) begin
			nxt_state.rdata = '0;
			case (idx)
				ACC_IDX_DIS:     nxt_state.rdata[ACC_REG_W-1:0] = state_ff.dis;
				ACC_IDX_CTRL_B:  nxt_state.rdata[ACC_REG_W-1:0] = state_ff.ctrl_b;
				ACC_IDX_CSR:     nxt_state.rdata[ACC_REG_W-1:0] = csr_view;
				ACC_IDX_IRQ_ST: begin
					nxt_state.rdata[ACC_IRQ_BIT] = state_ff.csr[ACC_CSR_FLAG];
				end
				ACC_IDX_IRQ_MSK: begin
					nxt_state.rdata[ACC_IRQ_BIT] = state_ff.csr[ACC_CSR_IE];
				end
				default:         nxt_state.rdata = '0;
			endcase
		end

		// register writes; unmapped writes are dropped
		if (commit_wr) begin
			case (idx)
				ACC_IDX_DIS: begin
					nxt_state.dis = wbyte & ACC_DIS_WMASK;
				end
				ACC_IDX_CTRL_B: begin
					nxt_state.ctrl_b = wbyte & ACC_CTB_WMASK;
				end
				ACC_IDX_CSR: begin
					// disable bit accepted at any time, even mid event
					nxt_state.csr = (wbyte & ACC_CSR_STORE)
						| (state_ff.csr & ~ACC_CSR_STORE);
				end
				ACC_IDX_IRQ_MSK: begin
					nxt_state.csr[ACC_CSR_IE] = wbyte[ACC_IRQ_BIT];
				end
				default: begin
					nxt_state.dis = state_ff.dis;
				end
			endcase
		end

		// sticky flag; a new event beats a clear in the same cycle
		if (flag_set) begin
			nxt_state.csr[ACC_CSR_FLAG] = 1'b1;
		end else if (flag_clr) begin
			nxt_state.csr[ACC_CSR_FLAG] = 1'b0;
		end else begin
			nxt_state.csr[ACC_CSR_FLAG] = state_ff.csr[ACC_CSR_FLAG];
		end
		nxt_state.csr[ACC_CSR_RESULT] = 1'b0;

		// interrupt level; software must drop the enable before mode or
		// disable changes, since a change can fake an edge
		nxt_state.irq = nxt_state.csr[ACC_CSR_FLAG]
			& nxt_state.csr[ACC_CSR_IE]
			& global_irq_enable;

		// negative input selection
		if (state_ff.ctrl_b[ACC_CTB_MUX_EN] && !converter_enable
				&& channel_select_code <= ACC_CHAN_LAST) begin
			nxt_state.neg_sel = {1'b0, channel_select_code[2:0]};
		end else begin
			nxt_state.neg_sel = ACC_NEG_PIN;
		end

		// positive input and power
		nxt_state.bandgap = state_ff.csr[ACC_CSR_REF];
		nxt_state.pwr_dn  = state_ff.csr[ACC_CSR_DISABLE];

		// timer capture path exists only while routed
		nxt_state.capture = state_ff.csr[ACC_CSR_CAPT] & result_sync;

		// gated port reads per pin
		nxt_state.port_rd = pin_digital_in & ~state_ff.dis[1:0];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff        <= '0;
			state_ff.bus    <= ACC_IDLE;
			state_ff.ctrl_b <= ACC_CTB_RESET;
			state_ff.csr    <= ACC_CSR_RESET;
			state_ff.dis    <= ACC_DIS_RESET;
			state_ff.neg_sel <= ACC_NEG_PIN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign readdata                = state_ff.rdata;
	assign waitrequest             = ~state_ff.wait_n;
	assign comparator_irq          = state_ff.irq;
	assign negative_input_select   = state_ff.neg_sel;
	assign positive_bandgap_select = state_ff.bandgap;
	assign comparator_power_down   = state_ff.pwr_dn;
	assign capture_input           = state_ff.capture;
	assign pin_buffer_disable      = state_ff.dis[1:0];
	assign port_read_value         = state_ff.port_rd;
endmodule
`default_nettype wire

// [test/acc_analog_model.sv]
// partner model: comparator core and analog pins facing the control block
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model #(
	parameter logic [7:0] BANDGAP_LEVEL = 8'h80
)(
	input  wire logic        power_down,
	input  wire logic        bandgap_sel,
	input  wire logic [3:0]  neg_sel,
	input  wire logic [7:0]  pos_level,
	input  wire logic [71:0] neg_levels,
	output var  logic        raw_out
);
	// ----
	// comparator
	// ----
	// levels are byte codes; a powered-down core idles low
	always_comb begin
		raw_out = 1'b0;
		if (!power_down) begin
			raw_out = (bandgap_sel ? BANDGAP_LEVEL : pos_level) > neg_levels[neg_sel*8 +: 8];
		end
	end
endmodule
`default_nettype wire

// [test/acc_monitor.sv]
// checker: port properties of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acc_monitor
	import acc_pkg::*;
#(
	parameter int SYNC_STAGES = 2
)(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       write,
	input wire logic       waitrequest,
	input wire logic       global_irq_enable,
	input wire logic       vector_taken,
	input wire logic       converter_enable,
	input wire logic [4:0] channel_select_code,
	input wire logic       comparator_raw,
	input wire logic [1:0] pin_digital_in,
	input wire logic       comparator_power_down,
	input wire logic       positive_bandgap_select,
	input wire logic [3:0] negative_input_select,
	input wire logic [1:0] pin_buffer_disable,
	input wire logic [1:0] port_read_value,
	input wire logic       capture_input,
	input wire logic       comparator_irq
);
	// ----
	// properties
	// ----
	default clocking mon_cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_irq_needs_gie: assert property (comparator_irq |-> $past(global_irq_enable))
		else $error("irq without global enable");
	// a request only drops on a clear, a write or a lost global enable
	a_irq_fall_cause: assert property ($fell(comparator_irq) |->
		$past(vector_taken || write || !global_irq_enable))
		else $error("irq dropped without cause");
	a_capture_follows: assert property (capture_input |->
		$past(comparator_raw, SYNC_STAGES + 1))
		else $error("capture without synced result");
	a_port_read_pass: assert property ($past(rst_n) && $stable(pin_digital_in) &&
		$stable(pin_buffer_disable) |-> port_read_value == (pin_digital_in & ~pin_buffer_disable))
		else $error("port read value wrong");
	a_neg_dedicated: assert property ($past(converter_enable) |->
		negative_input_select == ACC_NEG_PIN)
		else $error("channel used while converter on");
	a_neg_channel: assert property (negative_input_select != ACC_NEG_PIN |->
		{1'b0, negative_input_select} == $past(channel_select_code) && !$past(converter_enable))
		else $error("channel select mismatch");
	// the output may trail the register by one stage, so allow two edges
	a_pd_by_write: assert property ($past(rst_n) && $changed(comparator_power_down) |->
		$past(write && !waitrequest) || $past(write && !waitrequest, 2))
		else $error("power down moved without write");
	a_bg_by_write: assert property ($past(rst_n) && $changed(positive_bandgap_select) |->
		$past(write && !waitrequest) || $past(write && !waitrequest, 2))
		else $error("reference moved without write");
	c_irq: cover property ($rose(comparator_irq));
	c_capture: cover property ($rose(capture_input));
	c_last_chan: cover property (negative_input_select == 4'h7);
endmodule
bind acc_top acc_monitor #(.SYNC_STAGES(SYNC_STAGES)) acc_monitor_inst (.*);
`default_nettype wire

// [test/analog_comparator_ctrl_test.sv]
// testbench: registers, input select, events and interrupt of the comparator control
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_ctrl_test
	import acc_pkg::*;
;
	logic        clock, rst_n, read, write, gie, vtaken, conv_en, raw, f;
	logic        waitrequest, pd, bg, capt, irq;
	logic [7:0]  address, pos_level;
	logic [31:0] writedata, readdata;
	logic [31:0] exp_q[$];
	logic [4:0]  chan;
	logic [3:0]  nsel;
	logic [1:0]  pin_in, bdis, prd;
	logic [71:0] neg_levels;
	int          n_errors, samples_checked, seed;
	acc_top #(.SYNC_STAGES(2)) acc_top_inst (
		.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.global_irq_enable(gie), .vector_taken(vtaken), .converter_enable(conv_en),
		.channel_select_code(chan), .comparator_raw(raw), .pin_digital_in(pin_in),
		.comparator_power_down(pd), .positive_bandgap_select(bg),
		.negative_input_select(nsel), .pin_buffer_disable(bdis), .port_read_value(prd),
		.capture_input(capt), .comparator_irq(irq)
	);
	acc_analog_model acc_analog_model_inst (
		.power_down(pd), .bandgap_sel(bg), .neg_sel(nsel), .pos_level(pos_level),
		.neg_levels(neg_levels), .raw_out(raw)
	);
	// ----
	// clock, watchdog, checking
	// ----
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// the sequence needs about 320 cycles; 4000 means a hang
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read data stand at the edge that sees waitrequest low
	always @(posedge clock) begin
		if (read && !waitrequest) begin
			cmp(readdata, exp_q.pop_front());
		end
	end
	// holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		do @(posedge clock); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, idx, 8'h00);
	endtask
	// ----
	// stimulus
	// ----
	initial begin
		seed = 70504;
		{rst_n, read, write, gie, vtaken, conv_en, chan, pin_in, address, writedata} = '0;
		pos_level = 8'h00;
		neg_levels = {8'h80, 64'h0};
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rd(ACC_IDX_CTRL_B, ACC_CTB_RESET);
		rd(ACC_IDX_DIS, ACC_DIS_RESET);
		rd(ACC_IDX_CSR, 8'h00);
		rd(6'h3F, 8'h00);
		bus(1'b1, ACC_IDX_CTRL_B, 8'hFF);
		rd(ACC_IDX_CTRL_B, ACC_CTB_WMASK);
		bus(1'b1, ACC_IDX_DIS, 8'hFF);
		rd(ACC_IDX_DIS, ACC_DIS_WMASK);
		pin_in <= 2'($random(seed)) | 2'h1;
		repeat (3) @(posedge clock);
		cmp({30'h0, prd}, 0);
		cmp({30'h0, bdis}, 32'h3);
		bus(1'b1, ACC_IDX_DIS, 8'h00);
		repeat (3) @(posedge clock);
		cmp({30'h0, prd}, {30'h0, pin_in});
		// reserved mode keeps the flag quiet while the result wanders
		bus(1'b1, ACC_IDX_CSR, {6'h0, ACC_MODE_RSVD});
		pos_level <= 8'h80;
		for (int ch = 0; ch < 8; ch++) begin
			chan <= ch[4:0];
			neg_levels[ch*8 +: 8] <= 8'($random(seed));
			repeat (5) @(posedge clock);
			cmp({28'h0, nsel}, ch);
			rd(ACC_IDX_CSR, {2'b0, 8'h80 > neg_levels[ch*8 +: 8], 5'h01});
		end
		conv_en <= 1'b1;
		repeat (2) @(posedge clock);
		cmp({28'h0, nsel}, {28'h0, ACC_NEG_PIN});
		conv_en <= 1'b0;
		bus(1'b1, ACC_IDX_CTRL_B, 8'h00);
		repeat (2) @(posedge clock);
		cmp({28'h0, nsel}, {28'h0, ACC_NEG_PIN});
		pos_level <= 8'h00;
		neg_levels[71:64] <= 8'h20;
		bus(1'b1, ACC_IDX_CSR, 8'h41);
		repeat (4) @(posedge clock);
		cmp({31'h0, bg}, 1);
		rd(ACC_IDX_CSR, 8'h61);
		// each mode sees a rise, a vector clear, a fall and a one-write clear
		for (int m = 0; m < 4; m++) begin
			gie <= !m[0];
			bus(1'b1, ACC_IDX_CSR, 8'h10 | m[7:0]);
			bus(1'b1, ACC_IDX_CSR, 8'h18 | m[7:0]);
			pos_level <= 8'hF0;
			repeat (5) @(posedge clock);
			f = (m == 0) || (m == 3);
			rd(ACC_IDX_CSR, {3'b001, f, 2'b10, m[1:0]});
			cmp({31'h0, irq}, {31'h0, f & !m[0]});
			bus(1'b1, ACC_IDX_CSR, 8'h28 | m[7:0]);
			rd(ACC_IDX_CSR, {3'b001, f, 2'b10, m[1:0]});
			vtaken <= 1'b1;
			@(posedge clock);
			vtaken <= 1'b0;
			pos_level <= 8'h00;
			repeat (5) @(posedge clock);
			f = (m == 0) || (m == 2);
			rd(ACC_IDX_CSR, {3'b000, f, 2'b10, m[1:0]});
			cmp({31'h0, irq}, {31'h0, f & !m[0]});
			bus(1'b1, ACC_IDX_CSR, 8'h10 | m[7:0]);
			rd(ACC_IDX_CSR, {6'h00, m[1:0]});
		end
		bus(1'b1, ACC_IDX_CSR, 8'h83);
		repeat (5) @(posedge clock);
		cmp({31'h0, pd}, 1);
		// raise the input only once the core is down, else a one-cycle
		// glitch reaches the synchroniser and fakes a rising edge
		pos_level <= 8'hF0;
		repeat (3) @(posedge clock);
		rd(ACC_IDX_CSR, 8'h83);
		bus(1'b1, ACC_IDX_CSR, 8'h04);
		repeat (5) @(posedge clock);
		cmp({31'h0, capt}, 1);
		bus(1'b1, ACC_IDX_CSR, 8'h10);
		repeat (3) @(posedge clock);
		cmp({31'h0, capt}, 0);
		// status and mask aliases: a toggle sets the flag, mask enables, one clears
		gie <= 1'b1;
		pos_level <= 8'h00;
		repeat (5) @(posedge clock);
		rd(ACC_IDX_IRQ_ST, 8'h01);
		bus(1'b1, ACC_IDX_IRQ_MSK, 8'h01);
		rd(ACC_IDX_CSR, 8'h18);
		cmp({31'h0, irq}, 1);
		bus(1'b1, ACC_IDX_IRQ_ST, 8'h01);
		rd(ACC_IDX_IRQ_MSK, 8'h01);
		cmp({31'h0, irq}, 0);
		rd(ACC_IDX_IRQ_ST, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
